// ### rtl/adc_result_computation_unit.sv
// Post-conversion computation unit: accumulator, tally, filter and flags.
// Assumes a converter core that takes o_conv_start and answers with a one-cycle
// i_conv_done beside i_conv_data; all inputs except the asynchronous i_rst_n synchronous to i_clock.
//
// Summary of operation
// [R1] Software sets clock, reference, channel and timing before turning the unit on.
// [R2] Software clears done flag and enables interrupts before start, clears after read.
// [R3] With nonzero acquisition count, software waits acquisition time before go.
// [R4] After a channel change, a full acquisition period passes before conversion.
// [R5] Go starts conversion; completion clears go and raises the done flag.
// [R6] Mode field picks basic, accumulate, average, burst average or low-pass.
// [R7] Computation results decide between further samples or stop, and set flags.
// [R8] Basic mode converts singles or pairs and leaves accumulator and tally alone.
// [R9] Basic mode sets done after each conversion and tests every sample.
// [R10] Basic and accumulate modes set threshold flag whenever the test holds.
// [R11] Accumulate adds sample or difference, tally increments and saturates at FF.
// [R12] Average tests at repeat target and clears on the following trigger.
// [R13] Burst clears at trigger, retriggers below target, tests at target.
// [R14] Low-pass: accumulator becomes sample plus accumulator minus shifted accumulator.
// [R15] Low-pass tests first at repeat target, then on every later trigger.
// [R16] Sample is current result, or current minus previous with double sampling.
// [R17] Clear command empties accumulator, overflow and tally, then drops itself.
// [R18] Overflow flag sets when the sum passes the 18-bit maximum.
// [R19] Filter output takes accumulator shifted right by shift amount after updates.
// [R20] Only burst mode restarts by itself; otherwise software, trigger or continuous.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps

module adc_result_computation_unit
    import adc_comp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire bus_req_s i_bus,
    input wire logic i_ext_trig,
    input wire logic i_conv_done,
    input wire logic [RES_W-1:0] i_conv_data,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_conv_start,
    output logic o_done_flag,
    output logic o_thresh_flag,
    output logic o_go
);

    unit_state_s s_q;
    unit_state_s s_d;

    logic signed [RES_W+1:0] sample_v;
    logic signed [SUM_W-1:0] sum_v;
    logic signed [SUM_W-1:0] value_v;
    logic [ACC_W-1:0] acc_new;
    logic [ACC_W-1:0] filt_new;
    logic [TALLY_W-1:0] tally_new;
    logic ovf_new;
    logic test_en;
    logic hit;
    logic retrig;
    logic accumulating;

    function automatic logic [ACC_W-1:0] scale(input logic [ACC_W-1:0] acc,
                                               input logic [SHIFT_W-1:0] sh);
        scale = acc >> sh;
    endfunction : scale

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.conv_start = 1'b0;
        s_d.rdata = '0;
        s_d.trig_prev = i_ext_trig;
        // Differential pair yields second minus first
        if (s_q.double_sample_enable) begin // [R16]
            sample_v = $signed({2'b00, s_q.result_word}) - $signed({2'b00, s_q.prior_result_word});
        end else begin
            sample_v = $signed({2'b00, s_q.result_word});
        end
        if (s_q.mode == MODE_LOWPASS) begin // [R14]
            sum_v = $signed({2'b00, s_q.accumulator_value})
                  - $signed({2'b00, scale(s_q.accumulator_value, s_q.shift_amount)})
                  + SUM_W'(sample_v);
        end else begin
            sum_v = $signed({2'b00, s_q.accumulator_value}) + SUM_W'(sample_v); // [R11]
        end
        ovf_new = sum_v > ACC_MAX; // [R18]
        acc_new = sum_v[ACC_W-1:0];
        filt_new = scale(acc_new, s_q.shift_amount);
        // Tally saturates rather than wrapping so a long run still reads as full
        tally_new = (s_q.sample_tally == TALLY_MAX) ? s_q.sample_tally
                                                    : s_q.sample_tally + 8'h01; // [R11]
        accumulating = s_q.mode inside {MODE_ACCUM, MODE_AVERAGE, MODE_BURST, MODE_LOWPASS};
        test_en = 1'b0;
        value_v = SUM_W'(sample_v);
        hit = 1'b0;
        retrig = 1'b0;

        // Register writes; hardware updates below win over software clears
        if (i_bus.wr) begin
            if (i_bus.addr == REG_CTRL) begin
                s_d.on = i_bus.wdata[CTRL_ON_BIT];
                s_d.cont = i_bus.wdata[CTRL_CONT_BIT];
                s_d.double_sample_enable = i_bus.wdata[CTRL_DOUBLE_BIT];
                s_d.stop_on_hit = i_bus.wdata[CTRL_STOP_BIT];
                s_d.mode = i_bus.wdata[CTRL_MODE_LSB +: 3];
                s_d.shift_amount = i_bus.wdata[CTRL_SHIFT_LSB +: SHIFT_W];
                if (i_bus.wdata[CTRL_GO_BIT] && s_q.on) begin
                    s_d.go = 1'b1;
                end
                if (i_bus.wdata[CTRL_CLEAR_BIT]) begin
                    s_d.accumulator_clear_cmd = 1'b1;
                end
            end else if (i_bus.addr == REG_REPEAT) begin
                s_d.repeat_target = i_bus.wdata[TALLY_W-1:0];
            end else if (i_bus.addr == REG_STATUS) begin
                if (i_bus.wdata[STAT_DONE_BIT]) begin
                    s_d.conversion_done_flag = 1'b0;
                end
                if (i_bus.wdata[STAT_THR_BIT]) begin
                    s_d.threshold_irq_flag = 1'b0;
                end
            end else if (i_bus.addr == REG_THRESH) begin
                s_d.threshold_level = i_bus.wdata[THR_W-1:0];
            end
        end
        if (s_q.on && i_ext_trig && !s_q.trig_prev) begin
            s_d.go = 1'b1;
        end

        case (s_q.phase)
            PH_IDLE: begin
                if (s_q.go && s_q.on) begin
                    s_d.phase = PH_CONVERT;
                    s_d.conv_start = 1'b1;
                    s_d.pair_second = 1'b0;
                    s_d.burst_inner = 1'b0;
                    if ((s_q.mode == MODE_AVERAGE && s_q.sample_tally >= s_q.repeat_target)
                        || (s_q.mode == MODE_BURST && !s_q.burst_inner)) begin // [R12] [R13]
                        s_d.accumulator_value = '0;
                        s_d.sample_tally = '0;
                    end
                end
            end
            PH_CONVERT: begin
                if (!s_q.on) begin
                    s_d.phase = PH_IDLE;
                    s_d.go = 1'b0;
                end else if (i_conv_done) begin
                    s_d.prior_result_word = s_q.result_word;
                    s_d.result_word = i_conv_data;
                    s_d.conversion_done_flag = 1'b1; // [R5] [R9]
                    if (s_q.double_sample_enable && !s_q.pair_second) begin // [R8]
                        s_d.pair_second = 1'b1;
                        s_d.conv_start = 1'b1;
                    end else begin
                        s_d.phase = PH_COMPUTE;
                    end
                end
            end
            PH_COMPUTE: begin
                if (accumulating) begin // [R6]
                    s_d.accumulator_value = acc_new;
                    s_d.sample_tally = tally_new;
                    s_d.filter_output = filt_new; // [R19]
                    if (ovf_new) begin
                        s_d.accumulator_overflow_flag = 1'b1; // [R18]
                    end
                    value_v = $signed({2'b00, filt_new});
                    test_en = (s_q.mode == MODE_ACCUM) || (tally_new >= s_q.repeat_target); // [R10] [R12] [R15]
                end else begin
                    test_en = 1'b1; // [R8] [R9] [R10]
                end
                hit = test_en && ((accumulating && (ovf_new || s_q.accumulator_overflow_flag))
                                  || value_v >= SUM_W'(s_q.threshold_level));
                if (hit) begin
                    s_d.threshold_irq_flag = 1'b1; // [R7] [R10]
                end
                if (s_q.mode == MODE_BURST && tally_new < s_q.repeat_target) begin // [R13]
                    retrig = 1'b1;
                    s_d.burst_inner = 1'b1;
                end else if (s_q.cont && !(s_q.stop_on_hit && hit)) begin
                    retrig = 1'b1;
                end
                s_d.go = retrig; // [R5] [R7] [R20]
                s_d.phase = PH_IDLE;
            end
            default: begin
                s_d.phase = PH_IDLE;
            end
        endcase

        // Clearing finishes in one cycle, so the command drops right after it
        if (s_q.accumulator_clear_cmd) begin // [R17]
            s_d.accumulator_value = '0;
            s_d.sample_tally = '0;
            s_d.accumulator_overflow_flag = 1'b0;
            s_d.accumulator_clear_cmd = 1'b0;
        end

        if (i_bus.rd) begin
            if (i_bus.addr == REG_CTRL) begin
                s_d.rdata[CTRL_ON_BIT] = s_q.on;
                s_d.rdata[CTRL_GO_BIT] = s_q.go;
                s_d.rdata[CTRL_CONT_BIT] = s_q.cont;
                s_d.rdata[CTRL_DOUBLE_BIT] = s_q.double_sample_enable;
                s_d.rdata[CTRL_CLEAR_BIT] = s_q.accumulator_clear_cmd;
                s_d.rdata[CTRL_STOP_BIT] = s_q.stop_on_hit;
                s_d.rdata[CTRL_MODE_LSB +: 3] = s_q.mode;
                s_d.rdata[CTRL_SHIFT_LSB +: SHIFT_W] = s_q.shift_amount;
            end else if (i_bus.addr == REG_REPEAT) begin
                s_d.rdata[TALLY_W-1:0] = s_q.repeat_target;
            end else if (i_bus.addr == REG_STATUS) begin
                s_d.rdata[STAT_DONE_BIT] = s_q.conversion_done_flag;
                s_d.rdata[STAT_THR_BIT] = s_q.threshold_irq_flag;
                s_d.rdata[STAT_OVF_BIT] = s_q.accumulator_overflow_flag;
            end else if (i_bus.addr == REG_RESULT) begin
                s_d.rdata[RES_W-1:0] = s_q.result_word;
            end else if (i_bus.addr == REG_PRIOR) begin
                s_d.rdata[RES_W-1:0] = s_q.prior_result_word;
            end else if (i_bus.addr == REG_ACC) begin
                s_d.rdata[ACC_W-1:0] = s_q.accumulator_value;
            end else if (i_bus.addr == REG_TALLY) begin
                s_d.rdata[TALLY_W-1:0] = s_q.sample_tally;
            end else if (i_bus.addr == REG_FILTER) begin
                s_d.rdata[ACC_W-1:0] = s_q.filter_output;
            end else if (i_bus.addr == REG_THRESH) begin
                s_d.rdata[THR_W-1:0] = s_q.threshold_level;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '{phase: PH_IDLE, mode: 3'h0, shift_amount: 3'h0,
                     repeat_target: REPEAT_RESET, threshold_level: THRESH_RESET,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_conv_start = s_q.conv_start;
    assign o_done_flag = s_q.conversion_done_flag;
    assign o_thresh_flag = s_q.threshold_irq_flag;
    assign o_go = s_q.go;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    AST_GO_CLEARS_AT_END: assert property ( // [R5]
        (s_q.phase == PH_COMPUTE && !s_q.cont && s_q.mode != MODE_BURST
         && !s_q.accumulator_clear_cmd) |=> !s_q.go && s_q.phase == PH_IDLE)
        else $error("go still set after a finished single cycle");

    AST_DONE_FLAG_SETS: assert property ( // [R9]
        (s_q.phase == PH_CONVERT && s_q.on && i_conv_done) |=> s_q.conversion_done_flag)
        else $error("done flag missing after conversion");

    AST_BASIC_KEEPS_ACC: assert property ( // [R8]
        (s_q.phase == PH_COMPUTE && s_q.mode == MODE_BASIC && !s_q.accumulator_clear_cmd)
        |=> $stable(s_q.accumulator_value) && $stable(s_q.sample_tally))
        else $error("basic mode changed accumulator or tally");

    AST_TALLY_SATURATES: assert property ( // [R11]
        (s_q.phase == PH_COMPUTE && s_q.mode == MODE_ACCUM && s_q.sample_tally == TALLY_MAX
         && !s_q.accumulator_clear_cmd) |=> s_q.sample_tally == TALLY_MAX)
        else $error("tally wrapped past FF");

    AST_CLEAR_CMD: assert property ( // [R17]
        s_q.accumulator_clear_cmd |=> s_q.accumulator_value == '0 && s_q.sample_tally == '0
        && !s_q.accumulator_overflow_flag && !s_q.accumulator_clear_cmd)
        else $error("clear command did not finish in one cycle");

    AST_FILTER_TRACKS: assert property ( // [R19]
        (s_q.phase == PH_COMPUTE && s_q.mode == MODE_ACCUM && !s_q.accumulator_clear_cmd
         && !(i_bus.wr && i_bus.addr == REG_CTRL))
        |=> s_q.filter_output == (s_q.accumulator_value >> s_q.shift_amount))
        else $error("filter output not the shifted accumulator");

    AST_BURST_RETRIGGERS: assert property ( // [R13]
        (s_q.phase == PH_COMPUTE && s_q.mode == MODE_BURST && s_q.on
         && s_q.sample_tally + 9'h001 < {1'b0, s_q.repeat_target}
         && !(i_bus.wr && i_bus.addr == REG_CTRL)) |=> ##1 s_q.conv_start)
        else $error("burst did not retrigger below target");

    AST_OVERFLOW_SETS: assert property ( // [R18]
        (s_q.phase == PH_COMPUTE && s_q.mode == MODE_ACCUM && ovf_new
         && !s_q.accumulator_clear_cmd) |=> s_q.accumulator_overflow_flag)
        else $error("overflow flag missed");

    AST_THRESH_ON_HIT: assert property ( // [R10]
        (s_q.phase == PH_COMPUTE && hit) |=> s_q.threshold_irq_flag)
        else $error("threshold flag missed");

    AST_AVG_CLEARS_ON_TRIGGER: assert property ( // [R12]
        (s_q.phase == PH_IDLE && s_q.go && s_q.on && s_q.mode == MODE_AVERAGE
         && s_q.sample_tally >= s_q.repeat_target && !s_q.accumulator_clear_cmd)
        |=> s_q.sample_tally == '0 && s_q.phase == PH_CONVERT)
        else $error("average mode kept stale samples");

    COV_PAIR: cover property (s_q.pair_second && s_q.phase == PH_COMPUTE);
    COV_BURST_END: cover property (s_q.mode == MODE_BURST && s_q.phase == PH_COMPUTE && !retrig);
    COV_LPF_HIT: cover property (s_q.mode == MODE_LOWPASS && hit);
    COV_OVERFLOW: cover property (s_q.accumulator_overflow_flag);

endmodule : adc_result_computation_unit

// ### include/adc_comp_pkg.sv
// Package for the post-conversion computation unit.
// Holds register map, field positions, widths, modes and the state carrier.
// Assumes a 10 MHz single clock domain and a plain one-cycle register port.
package adc_comp_pkg;

    // ==========================================================
    // Widths
    localparam int RES_W = 12;
    localparam int ACC_W = 18;
    localparam int SUM_W = ACC_W + 2;
    localparam int TALLY_W = 8;
    localparam int SHIFT_W = 3;
    localparam int THR_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ==========================================================
    // Register indices on the register port
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_REPEAT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] REG_RESULT = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PRIOR = 4'h4;
    localparam logic [ADDR_W-1:0] REG_ACC = 4'h5;
    localparam logic [ADDR_W-1:0] REG_TALLY = 4'h6;
    localparam logic [ADDR_W-1:0] REG_FILTER = 4'h7;
    localparam logic [ADDR_W-1:0] REG_THRESH = 4'h8;

    // ==========================================================
    // Field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_CONT_BIT = 2;
    localparam int CTRL_DOUBLE_BIT = 3;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int CTRL_STOP_BIT = 5;
    localparam int CTRL_MODE_LSB = 8;
    localparam int CTRL_SHIFT_LSB = 12;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_THR_BIT = 1;
    localparam int STAT_OVF_BIT = 2;

    // ==========================================================
    // Limits and reset values
    localparam logic [TALLY_W-1:0] TALLY_MAX = 8'hFF;
    localparam logic signed [SUM_W-1:0] ACC_MAX = 20'sh3FFFF;
    localparam logic [TALLY_W-1:0] REPEAT_RESET = 8'h00;
    localparam logic [THR_W-1:0] THRESH_RESET = 16'h0000;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MODE_BASIC,
        MODE_ACCUM,
        MODE_AVERAGE,
        MODE_BURST,
        MODE_LOWPASS
    } computation_mode_select_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CONVERT,
        PH_COMPUTE
    } phase_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    typedef struct packed {
        phase_e phase;
        logic on;
        logic go;
        logic cont;
        logic double_sample_enable;
        logic accumulator_clear_cmd;
        logic stop_on_hit;
        logic [2:0] mode;
        logic [SHIFT_W-1:0] shift_amount;
        logic [TALLY_W-1:0] repeat_target;
        logic signed [THR_W-1:0] threshold_level;
        logic conversion_done_flag;
        logic threshold_irq_flag;
        logic accumulator_overflow_flag;
        logic [RES_W-1:0] result_word;
        logic [RES_W-1:0] prior_result_word;
        logic [ACC_W-1:0] accumulator_value;
        logic [TALLY_W-1:0] sample_tally;
        logic [ACC_W-1:0] filter_output;
        logic pair_second;
        logic burst_inner;
        logic trig_prev;
        logic conv_start;
        logic [DATA_W-1:0] rdata;
    } unit_state_s;

endpackage : adc_comp_pkg

// ### bench/adc_result_computation_unit_tb.sv
// Self-checking bench for the post-conversion computation unit.
// Drives the register port and stands in for the converter core; one clock domain.
`timescale 1ns/1ps

module adc_result_computation_unit_tb
    import adc_comp_pkg::*;
;
    typedef struct {
        logic [2:0] mode;
        logic [2:0] shift;
        logic [7:0] rep;
        logic [15:0] thr;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [31:0] acc;
        logic [31:0] tally;
        logic [31:0] filt;
        logic tf;
    } row_s;

    logic i_clock;
    logic i_rst_n;
    logic i_ext_trig;
    logic i_conv_done;
    logic [RES_W-1:0] i_conv_data;
    bus_req_s bus;
    logic [DATA_W-1:0] o_rdata;
    logic o_conv_start;
    logic o_done_flag;
    logic o_thresh_flag;
    logic o_go;
    row_s rows [4];
    logic [ADDR_W-1:0] zero_addrs [5];
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    adc_result_computation_unit DUT (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_bus(bus),
        .i_ext_trig(i_ext_trig),
        .i_conv_done(i_conv_done),
        .i_conv_data(i_conv_data),
        .o_rdata(o_rdata),
        .o_conv_start(o_conv_start),
        .o_done_flag(o_done_flag),
        .o_thresh_flag(o_thresh_flag),
        .o_go(o_go)
    );

    // ==========================================================
    // Bus, converter and compare tasks
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clock);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clock);
        bus <= '0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is sampled there
    task rd_check(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: '0};
        @(posedge i_clock);
        bus <= '0;
        @(negedge i_clock);
        check_word(what, exp, o_rdata);
    endtask : rd_check

    function automatic logic [31:0] ctrl(input logic go, input logic dbl, input logic clr,
            input logic [2:0] mode, input logic [2:0] sh);
        ctrl = '0;
        ctrl[CTRL_ON_BIT] = 1'b1;
        ctrl[CTRL_GO_BIT] = go;
        ctrl[CTRL_DOUBLE_BIT] = dbl;
        ctrl[CTRL_CLEAR_BIT] = clr;
        ctrl[CTRL_MODE_LSB +: 3] = mode;
        ctrl[CTRL_SHIFT_LSB +: 3] = sh;
    endfunction : ctrl

    // Converter stand-in: waits for a start, answers one cycle later.
    // The data line is inverted after the answer so a stale value is never reused.
    task conv(input logic [RES_W-1:0] d, input logic tail);
        int n;
        n = 0;
        @(negedge i_clock);
        while (o_conv_start !== 1'b1 && n < 50) begin
            @(negedge i_clock);
            n++;
        end
        check_bit("conv start", 1'b1, o_conv_start);
        @(posedge i_clock);
        i_conv_done <= 1'b1;
        i_conv_data <= d;
        @(posedge i_clock);
        i_conv_done <= 1'b0;
        i_conv_data <= ~d;
        // Only the compute edge is waited for: a retriggered start comes one cycle later
        if (tail) begin
            @(posedge i_clock);
            @(negedge i_clock);
        end
    endtask : conv

    // ==========================================================
    // Clock, reset and hang guard
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        i_rst_n = 1'b0;
        i_ext_trig = 1'b0;
        i_conv_done = 1'b0;
        i_conv_data = '0;
        bus = '0;
        rows[0] = '{3'h0, 3'h0, 8'h02, 16'h003C, 12'h032, 12'h064, 32'h0, 32'h0, 32'h0, 1'b1};
        rows[1] = '{3'h1, 3'h1, 8'h02, 16'h004B, 12'h064, 12'h032, 32'h96, 32'h2, 32'h4B, 1'b1};
        rows[2] = '{3'h2, 3'h1, 8'h03, 16'h000A, 12'h064, 12'h032, 32'h96, 32'h2, 32'h4B, 1'b0};
        rows[3] = '{3'h4, 3'h1, 8'h02, 16'h0032, 12'h064, 12'h032, 32'h64, 32'h2, 32'h32, 1'b1};
        zero_addrs = '{REG_CTRL, REG_REPEAT, REG_STATUS, REG_THRESH, 4'hF};
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(negedge i_clock);
        check_word("outputs", 32'h0, {28'h0, o_conv_start, o_done_flag, o_thresh_flag, o_go});
        foreach (zero_addrs[k]) rd_check("reset reg", zero_addrs[k], 32'h0);
        // Go alone, or beside the write that turns the unit on, must be ignored
        wr(REG_CTRL, 32'h2);
        repeat (2) @(negedge i_clock);
        check_bit("go off", 1'b0, o_go);
        wr(REG_CTRL, 32'h3);
        repeat (2) @(negedge i_clock);
        check_bit("go same write", 1'b0, o_go);
        $display("test reset complete");

        for (int r = 0; r < 4; r++) begin
            wr(REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, rows[r].mode, rows[r].shift));
            wr(REG_STATUS, 32'h3);
            wr(REG_REPEAT, {24'h0, rows[r].rep});
            wr(REG_THRESH, {16'h0, rows[r].thr});
            // Stands in for the acquisition wait that software owes before go
            repeat (4) @(posedge i_clock);
            wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, rows[r].mode, rows[r].shift));
            conv(rows[r].s1, 1'b1);
            wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, rows[r].mode, rows[r].shift));
            conv(rows[r].s2, 1'b1);
            check_bit("go", 1'b0, o_go);
            check_bit("done", 1'b1, o_done_flag);
            check_bit("thresh", rows[r].tf, o_thresh_flag);
            rd_check("acc", REG_ACC, rows[r].acc);
            rd_check("tally", REG_TALLY, rows[r].tally);
            rd_check("filter", REG_FILTER, rows[r].filt);
            $display("test mode row %0d complete", r);
        end

        // Burst starts from the low-pass leftovers and must clear them itself
        wr(REG_REPEAT, 32'h3);
        wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, MODE_BURST, 3'h0));
        conv(12'h00A, 1'b1);
        conv(12'h014, 1'b1);
        conv(12'h01E, 1'b1);
        check_bit("burst go", 1'b0, o_go);
        rd_check("burst acc", REG_ACC, 32'h3C);
        rd_check("burst tally", REG_TALLY, 32'h3);
        rd_check("burst filter", REG_FILTER, 32'h3C);
        $display("test burst complete");

        // Pair from an external edge: second minus first, one tally step
        wr(REG_CTRL, ctrl(1'b0, 1'b1, 1'b1, MODE_ACCUM, 3'h0));
        @(posedge i_clock);
        i_ext_trig <= 1'b1;
        @(posedge i_clock);
        i_ext_trig <= 1'b0;
        conv(12'h01E, 1'b0);
        conv(12'h064, 1'b1);
        rd_check("pair acc", REG_ACC, 32'h46);
        rd_check("pair prior", REG_PRIOR, 32'h1E);
        rd_check("pair result", REG_RESULT, 32'h64);
        rd_check("pair tally", REG_TALLY, 32'h1);
        $display("test double sample complete");

        // Continuous basic run keeps go up until a threshold hit stops it
        wr(REG_THRESH, 32'h50);
        wr(REG_STATUS, 32'h3);
        wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, MODE_BASIC, 3'h0)
                     | (32'h1 << CTRL_CONT_BIT) | (32'h1 << CTRL_STOP_BIT));
        conv(12'h010, 1'b1);
        check_bit("cont go", 1'b1, o_go);
        check_bit("cont thresh", 1'b0, o_thresh_flag);
        conv(12'h060, 1'b1);
        check_bit("stop go", 1'b0, o_go);
        check_bit("stop thresh", 1'b1, o_thresh_flag);
        $display("test continuous complete");

        // Average: the trigger after a full set starts the sum afresh
        wr(REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, MODE_AVERAGE, 3'h1));
        wr(REG_REPEAT, 32'h2);
        repeat (3) begin
            wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, MODE_AVERAGE, 3'h1));
            conv(12'h040, 1'b1);
        end
        rd_check("avg acc", REG_ACC, 32'h40);
        rd_check("avg tally", REG_TALLY, 32'h1);
        rd_check("avg filter", REG_FILTER, 32'h20);
        $display("test average restart complete");

        // Tally saturation, then overflow and the clear command
        wr(REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, MODE_ACCUM, 3'h0));
        for (int k = 0; k < 256; k++) begin
            wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, MODE_ACCUM, 3'h0));
            conv(12'h3E8, 1'b1);
        end
        rd_check("sat tally", REG_TALLY, 32'hFF);
        rd_check("sat acc", REG_ACC, 32'h3E800);
        wr(REG_THRESH, 32'h7FFF);
        wr(REG_STATUS, 32'h3);
        repeat (2) begin
            wr(REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, MODE_ACCUM, 3'h0));
            conv(12'hFFF, 1'b1);
        end
        rd_check("ovf status", REG_STATUS, 32'h7);
        rd_check("ovf acc", REG_ACC, 32'h7FE);
        wr(REG_STATUS, 32'h7);
        rd_check("ovf kept", REG_STATUS, 32'h4);
        wr(REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, MODE_ACCUM, 3'h0));
        rd_check("clear ctrl", REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, MODE_ACCUM, 3'h0));
        rd_check("clear acc", REG_ACC, 32'h0);
        rd_check("clear tally", REG_TALLY, 32'h0);
        rd_check("clear status", REG_STATUS, 32'h0);
        $display("test saturation and clear complete");
        results();
    end
endmodule : adc_result_computation_unit_tb
